// ---- rtl/adc_input_config_select.sv ----
// What the datasheet requires of this block and its controller
// R1: a low input-type pin groups each converter's inputs as three pairs, high as six single inputs.
// R2: the controller keeps the input-type pin steady from before acquisition through conversion.
// R3: the sampler returns to track on the 13th rising serial-clock edge after chip select falls.
// R4: one three-bit address drives both converters and may change mid-conversion if the type does not.
// R5: a change of input type restarts the acquisition period from that moment.
// R6: in single-ended mode codes 000 to 101 pick inputs 1 to 6 against analog ground.
// R7: in differential mode the upper bits pick a pair and the low bit picks full or pseudo.
// R8: the controller holds the range pin from one acquisition time before chip select until the third falling edge.
// R9: a low range pin gives a span of one reference, high gives two references.
// R10: straight binary only for single or pseudo inputs on the narrow span, else twos complement.
// R11: single-ended step is vref/4096 narrow and twice that wide.
// R12: differential step is 2*vref/4096 narrow and 4*vref/4096 wide.
// R13: chip select falling samples the chosen inputs and starts conversion.
// R14: conversion and readout take fourteen serial-clock cycles after chip select falls.
// R15: address codes 110 and 111 are undefined and are not to be applied.
`timescale 1ns/1ps
`default_nettype none
module adc_input_config_select
    import input_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        input_type_select,
    input  wire logic        chan_addr_bit0,
    input  wire logic        chan_addr_bit1,
    input  wire logic        chan_addr_bit2,
    input  wire logic        range_sel,
    output logic             tracking,
    output logic             conv_active,
    output logic             conv_done,
    output logic             acq_restart,
    output logic [1:0]       active_mode,
    output logic [2:0]       pos_chan,
    output logic [2:0]       neg_chan,
    output logic             range_wide,
    output logic             twos_comp,
    output logic [2:0]       step_mult,
    output logic             live_mode_bad
);
    // every pin is asynchronous to clk; two stages before use
    // only the second stage feeds logic; the first may still be settling
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] next_sync1;
    logic [6:0] next_sync2;

    always_comb begin
        next_sync1 = {cs_n, sclk, input_type_select, chan_addr_bit2,
                      chan_addr_bit1, chan_addr_bit0, range_sel};
        next_sync2 = sync1;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1 <= 7'h7f;
            sync2 <= 7'h7f;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    logic       cs_s;
    logic       sclk_s;
    logic       type_s;
    logic [2:0] addr_s;
    logic       range_s;
    assign cs_s    = sync2[6];
    assign sclk_s  = sync2[5];
    assign type_s  = sync2[4];
    assign addr_s  = sync2[3:1];
    assign range_s = sync2[0];

    // live decode of the pins, used for the latch at chip select
    select_if live ();
    assign live.input_type_select = type_s;
    assign live.chan_addr         = addr_s; // R4
    assign live.range_wide        = range_s;
    input_decode u_live (
        .sel (live)
    );

    phase_t      phase;
    phase_t      next_phase;
    logic        cs_d;
    logic        sclk_d;
    logic        type_d;
    logic        addr0_d;
    logic [4:0]  rise_cnt;
    logic [4:0]  fall_cnt;
    logic [4:0]  next_rise_cnt;
    logic [4:0]  next_fall_cnt;
    input_mode_t held_mode;
    input_mode_t next_held_mode;
    logic [2:0]  next_pos;
    logic [2:0]  next_neg;
    logic        next_range;
    logic        next_twos;
    logic [2:0]  next_step;
    logic        next_done;
    logic        next_restart;
    logic        cs_fall;
    logic        sclk_rise;
    logic        sclk_fall;

    // one detector for the chip-select and serial-clock edges, so the edge polarity lives in one place
    function automatic logic pin_edge(input logic prev, input logic now, input logic rising);
        return rising ? (!prev && now) : (prev && !now);
    endfunction

    assign cs_fall   = pin_edge(cs_d, cs_s, 1'b0);
    assign sclk_rise = pin_edge(sclk_d, sclk_s, 1'b1);
    assign sclk_fall = pin_edge(sclk_d, sclk_s, 1'b0);

    always_comb begin
        next_phase     = phase;
        next_rise_cnt  = rise_cnt;
        next_fall_cnt  = fall_cnt;
        next_held_mode = held_mode;
        next_pos       = pos_chan;
        next_neg       = neg_chan;
        next_range     = range_wide;
        next_twos      = twos_comp;
        next_step      = step_mult;
        next_done      = 1'b0;
        // a change of input type restarts acquisition, and so does full/pseudo
        // switching on the low address bit while differential; held conversions ignore both
        next_restart   = (phase != PH_HOLD)
                         && ((type_s != type_d)
                             || (!type_s && !type_d && addr_s[0] != addr0_d)); // R5
        if (cs_s) begin
            next_phase    = PH_TRACK;
            next_rise_cnt = 5'h00;
            next_fall_cnt = 5'h00;
        end
        // everything the conversion needs is captured at once; later pin moves stay out
        if (cs_fall) begin
            next_phase     = PH_HOLD; // R13
            next_rise_cnt  = 5'h00;
            next_fall_cnt  = 5'h00;
            next_held_mode = live.mode; // R1
            next_pos       = live.pos_chan; // R6
            next_neg       = live.neg_chan; // R7
            next_range     = range_s; // R9
            next_twos      = live.twos_comp; // R10
            next_step      = live.step_mult; // R11 R12
        end else if (!cs_s) begin
            // counts stop at fourteen so a long burst cannot run into a second frame
            if (sclk_rise && rise_cnt != FRAME_CYCLES) begin
                next_rise_cnt = rise_cnt + 5'h01;
                if (rise_cnt + 5'h01 == TRACK_RISE_EDGE) begin
                    next_phase = PH_TRACKED; // R3
                end
            end
            if (sclk_fall && fall_cnt != FRAME_CYCLES) begin
                next_fall_cnt = fall_cnt + 5'h01;
                if (fall_cnt + 5'h01 == FRAME_CYCLES) begin
                    next_done = 1'b1; // R14
                end
            end
            // range is taken at the frame start; later pin moves are ignored
            if (phase == PH_HOLD && fall_cnt < RANGE_HOLD_FALL) begin
                next_range = range_wide; // R8
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase       <= PH_TRACK;
            rise_cnt    <= 5'h00;
            fall_cnt    <= 5'h00;
            held_mode   <= MODE_SINGLE;
            pos_chan    <= 3'h0;
            neg_chan    <= CHAN_GROUND;
            range_wide  <= 1'b0;
            twos_comp   <= 1'b0;
            step_mult   <= STEP_SGL_NARROW;
            conv_done   <= 1'b0;
            acq_restart <= 1'b0;
        end else begin
            phase       <= next_phase;
            rise_cnt    <= next_rise_cnt;
            fall_cnt    <= next_fall_cnt;
            held_mode   <= next_held_mode;
            pos_chan    <= next_pos;
            neg_chan    <= next_neg;
            range_wide  <= next_range;
            twos_comp   <= next_twos;
            step_mult   <= next_step;
            conv_done   <= next_done;
            acq_restart <= next_restart;
        end
    end

    // edge history starts at the synchroniser reset value, so leaving reset
    // shows no edge until a pin really differs from it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cs_d    <= 1'b1;
            sclk_d  <= 1'b1;
            type_d  <= 1'b1;
            addr0_d <= 1'b1;
        end else begin
            cs_d    <= cs_s;
            sclk_d  <= sclk_s;
            type_d  <= type_s;
            addr0_d <= addr_s[0];
        end
    end

    // tracking follows the phase register directly, no extra cycle of delay
    assign tracking      = (phase != PH_HOLD); // R3
    assign conv_active   = (phase == PH_HOLD);
    assign active_mode   = held_mode;
    // reports an unsupported address while it is on the pins, not only at frame start
    assign live_mode_bad = (live.mode == MODE_BAD); // R15
endmodule
`default_nettype wire

// ---- rtl/input_cfg_pkg.sv ----
package input_cfg_pkg;
    localparam int          ADDR_W            = 3;
    localparam int          CHAN_W            = 3;
    localparam int          COUNT_W           = 5;
    localparam int          RESULT_W          = 12;
    localparam logic [4:0]  TRACK_RISE_EDGE   = 5'h0d;
    localparam logic [4:0]  RANGE_HOLD_FALL   = 5'h03;
    localparam logic [4:0]  FRAME_CYCLES      = 5'h0e;
    localparam logic [1:0]  PAIR_LAST_CODE    = 2'h2;
    localparam logic [2:0]  SGL_LAST_CODE     = 3'h5;
    localparam int          LSB_DIVISOR       = 4096;
    // step size expressed as a multiple of vref/4096
    localparam logic [2:0]  STEP_SGL_NARROW   = 3'h1;
    localparam logic [2:0]  STEP_SGL_WIDE     = 3'h2;
    localparam logic [2:0]  STEP_DIFF_NARROW  = 3'h2;
    localparam logic [2:0]  STEP_DIFF_WIDE    = 3'h4;
    localparam logic [2:0]  CHAN_GROUND       = 3'h7;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_FULL   = 2'b01,
        MODE_PSEUDO = 2'b10,
        MODE_BAD    = 2'b11
    } input_mode_t;

    typedef enum logic [1:0] {
        PH_TRACK   = 2'b00,
        PH_HOLD    = 2'b01,
        PH_TRACKED = 2'b10
    } phase_t;
endpackage

// ---- rtl/input_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module input_decode
    import input_cfg_pkg::*;
(
    select_if.dec sel
);
    always_comb begin
        sel.mode      = MODE_BAD;
        sel.pos_chan  = CHAN_GROUND;
        sel.neg_chan  = CHAN_GROUND;
        if (sel.input_type_select) begin
            if (sel.chan_addr <= SGL_LAST_CODE) begin
                sel.mode     = MODE_SINGLE; // R1
                sel.pos_chan = sel.chan_addr; // R6
                sel.neg_chan = CHAN_GROUND; // R6
            end
        end else if (sel.chan_addr[2:1] <= PAIR_LAST_CODE) begin
            sel.mode     = sel.chan_addr[0] ? MODE_PSEUDO : MODE_FULL; // R7
            sel.pos_chan = {sel.chan_addr[2:1], 1'b0}; // R1
            sel.neg_chan = {sel.chan_addr[2:1], 1'b1}; // R7
        end
        // codes 110/111 fall through as MODE_BAD; behaviour is unspecified
        sel.twos_comp = sel.range_wide || (sel.mode == MODE_FULL); // R10
        if (sel.mode == MODE_SINGLE) begin
            sel.step_mult = sel.range_wide ? STEP_SGL_WIDE : STEP_SGL_NARROW; // R11
        end else begin
            sel.step_mult = sel.range_wide ? STEP_DIFF_WIDE : STEP_DIFF_NARROW; // R12
        end
    end
endmodule
`default_nettype wire

// ---- rtl/select_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface select_if;
    import input_cfg_pkg::*;
    logic        input_type_select;
    logic [2:0]  chan_addr;
    logic        range_wide;
    input_mode_t mode;
    logic [2:0]  pos_chan;
    logic [2:0]  neg_chan;
    logic        twos_comp;
    logic [2:0]  step_mult;
    modport src (output input_type_select, chan_addr, range_wide,
                 input mode, pos_chan, neg_chan, twos_comp, step_mult);
    modport dec (input input_type_select, chan_addr, range_wide,
                 output mode, pos_chan, neg_chan, twos_comp, step_mult);
endinterface
`default_nettype wire

// ---- test/adc_input_config_select_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_sel_checker
    import input_cfg_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       cs_n,
    input wire logic       range_sel,
    input wire logic       tracking,
    input wire logic       conv_active,
    input wire logic       conv_done,
    input wire logic       acq_restart,
    input wire logic [1:0] active_mode,
    input wire logic [2:0] pos_chan,
    input wire logic [2:0] neg_chan,
    input wire logic       range_wide,
    input wire logic       twos_comp,
    input wire logic [2:0] step_mult
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_open; $rose(conv_active); endsequence
    property p_ground; active_mode == MODE_SINGLE |-> neg_chan == CHAN_GROUND; endproperty
    a_ground: assert property (p_ground) else $error("single without ground");
    property p_pair; active_mode inside {MODE_FULL, MODE_PSEUDO}
        |-> !pos_chan[0] && neg_chan == pos_chan + 3'h1; endproperty
    a_pair: assert property (p_pair) else $error("pair mismatch");
    property p_fmt; twos_comp == (range_wide || active_mode == MODE_FULL); endproperty
    a_fmt: assert property (p_fmt) else $error("code format wrong");
    property p_step_sgl; active_mode == MODE_SINGLE
        |-> step_mult == (range_wide ? STEP_SGL_WIDE : STEP_SGL_NARROW); endproperty
    a_step_sgl: assert property (p_step_sgl) else $error("single step wrong");
    property p_step_diff; active_mode inside {MODE_FULL, MODE_PSEUDO}
        |-> step_mult == (range_wide ? STEP_DIFF_WIDE : STEP_DIFF_NARROW); endproperty
    a_step_diff: assert property (p_step_diff) else $error("pair step wrong");
    property p_latch; s_open |-> ##1 range_wide == range_sel; endproperty
    a_latch: assert property (p_latch) else $error("span not latched");
    // latch settles within a cycle of the frame opening, so skip two
    property p_hold; conv_active && $past(conv_active, 2) |-> $stable({pos_chan, range_wide});
    endproperty
    a_hold: assert property (p_hold) else $error("selection moved in frame");
    // two synchroniser stages and the edge detector put the hold three cycles after the pin
    property p_track; $fell(cs_n) |-> ##3 (conv_active && !tracking); endproperty
    a_track: assert property (p_track) else $error("sampler not holding");
    property p_done; conv_done |-> tracking ##1 !conv_done; endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
    property p_restart; acq_restart |-> tracking ##1 !acq_restart; endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
endmodule
bind adc_input_config_select cfg_sel_checker u_chk (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .range_sel(range_sel), .tracking(tracking),
    .conv_active(conv_active), .conv_done(conv_done), .acq_restart(acq_restart),
    .active_mode(active_mode), .pos_chan(pos_chan), .neg_chan(neg_chan),
    .range_wide(range_wide), .twos_comp(twos_comp), .step_mult(step_mult));
`default_nettype wire

// ---- test/adc_input_config_select_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_input_config_select_tb_top;
    import input_cfg_pkg::*;
    logic        clk, reset_n;
    wire logic   cs_n, sclk, input_type_select, range_sel;
    logic        tracking, conv_active, conv_done, acq_restart;
    logic        range_wide, twos_comp, live_mode_bad;
    logic [1:0]  active_mode;
    wire logic [2:0] chan_addr;
    logic [2:0]  pos_chan, neg_chan, step_mult;
    logic [12:0] held;
    int          err_total, compares, dones, restarts;
    assign held = {active_mode, pos_chan, neg_chan, range_wide, twos_comp, step_mult};
    adc_input_config_select DUT (
        .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
        .input_type_select(input_type_select), .chan_addr_bit0(chan_addr[0]),
        .chan_addr_bit1(chan_addr[1]), .chan_addr_bit2(chan_addr[2]),
        .range_sel(range_sel), .tracking(tracking), .conv_active(conv_active),
        .conv_done(conv_done), .acq_restart(acq_restart), .active_mode(active_mode),
        .pos_chan(pos_chan), .neg_chan(neg_chan), .range_wide(range_wide),
        .twos_comp(twos_comp), .step_mult(step_mult), .live_mode_bad(live_mode_bad));
    host_pins_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .chan_addr(chan_addr),
        .input_type_select(input_type_select), .range_sel(range_sel));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (conv_done === 1'b1)
            dones <= dones + 1;
        if (acq_restart === 1'b1)
            restarts <= restarts + 1;
    end
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // cs is raised before release so the synchronizers see no stray fall
    task automatic do_reset();
        @(negedge clk);
        reset_n = 1'b0;
        host.frame_edge(1'b1);
        chk({tracking, conv_active, conv_done, acq_restart, held}, 20'h1_00e1);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic type_flip();
        int r0;
        host.pulses(3);
        chk({tracking, conv_active, 8'(dones)}, {2'b10, 8'h00});
        host.setup(1'b0, 3'h0, 1'b0);
        r0 = restarts;
        host.setup(1'b1, 3'h0, 1'b0);
        host.setup(1'b1, 3'h2, 1'b1);
        host.setup(1'b0, 3'h2, 1'b0);
        host.setup(1'b0, 3'h3, 1'b0);
        chk(20'(restarts - r0), 20'h0_0003);
    endtask
    task automatic run_frame(input logic t, input logic [2:0] a, input logic r);
        logic [12:0] exp;
        int          d0;
        exp = t ? {MODE_SINGLE, a, CHAN_GROUND, r, r, r ? STEP_SGL_WIDE : STEP_SGL_NARROW}
              : {a[0] ? MODE_PSEUDO : MODE_FULL, a[2:1], 1'b0, a[2:1], 1'b1, r, r | ~a[0],
                 r ? STEP_DIFF_WIDE : STEP_DIFF_NARROW};
        host.setup(t, a, r);
        d0 = dones;
        host.frame_edge(1'b0);
        chk({live_mode_bad, tracking, conv_active, held}, {3'b001, exp});
        host.pulses(12);
        chk({tracking, conv_active, held}, {2'b01, exp});
        host.pulses(1);
        chk({tracking, conv_active, 8'(dones - d0)}, {2'b10, 8'h00});
        host.pulses(3);
        chk({tracking, 8'(dones - d0)}, {1'b1, 8'h01});
        host.frame_edge(1'b1);
    endtask
    initial begin
        reset_n = 1'b0;
        do_reset();
        $display("test reset done");
        type_flip();
        $display("test type change done");
        for (int i = 0; i < 24; i++)
            run_frame(i[0], 3'(i >> 2), i[1]);
        $display("test frames done");
        host.setup(1'b1, 3'h5, 1'b1);
        host.frame_edge(1'b0);
        host.pulses(5);
        do_reset();
        run_frame(1'b0, 3'h4, 1'b1);
        $display("test reset in frame done");
        close_out();
    end
    initial begin
        #200000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire

// ---- test/host_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
    input  wire logic  clk,
    output logic       cs_n,
    output logic       sclk,
    output logic       input_type_select,
    output logic [2:0] chan_addr,
    output logic       range_sel
);
    int falls;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        input_type_select = 1'b1;
        chan_addr = 3'h0;
        range_sel = 1'b0;
    end
    // pins settle a whole serial period before the frame opens
    task automatic setup(input logic t, input logic [2:0] a, input logic r);
        @(negedge clk);
        input_type_select = t;
        chan_addr = a;
        range_sel = r;
        repeat (8) @(negedge clk);
    endtask
    task automatic frame_edge(input logic level);
        @(negedge clk);
        cs_n = level;
        falls = 0;
        repeat (4) @(negedge clk);
    endtask
    // link clock idles high and toggles only when asked
    task automatic pulses(input int n);
        repeat (n) begin
            sclk = 1'b0;
            falls++;
            repeat (4) @(negedge clk);
            if (falls == 3) begin
                range_sel = ~range_sel;
                // moves the address but never the mode: single-ended steps to the
                // neighbour input, differential steps to the next pair
                if (input_type_select)
                    chan_addr = chan_addr ^ 3'h1;
                else
                    chan_addr = {(chan_addr[2:1] == 2'h2) ? 2'h0 : chan_addr[2:1] + 2'h1,
                                 chan_addr[0]};
            end
            sclk = 1'b1;
            repeat (4) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire
